// [common/adcc_consts.vh]
// named constants for the converter clock, reference and result control block
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ADCC_OFF_CTRL      12'h000
`define ADCC_OFF_SETUP     12'h004
`define ADCC_OFF_OUTCOME   12'h008
`define ADCC_OFF_INT_STAT  12'h00c
`define ADCC_OFF_INT_MASK  12'h010
`define ADCC_ADDR_W        12

// ****************************************
// control register fields
// ****************************************
`define ADCC_CTRL_ON       0
`define ADCC_CTRL_GO       1
`define ADCC_CTRL_CH_LO    2
`define ADCC_CTRL_CH_HI    5
`define ADCC_CH_FIXED_REF  4'hf

// ****************************************
// setup register fields
// ****************************************
`define ADCC_SETUP_REF_LO  0
`define ADCC_SETUP_REF_HI  1
`define ADCC_SETUP_CLK_LO  4
`define ADCC_SETUP_CLK_HI  6
`define ADCC_SETUP_MASK    8'h73
`define ADCC_REF_EXT       2'h2
`define ADCC_REF_FIXED     2'h3

// ****************************************
// reference routing codes to the analog side
// ****************************************
`define ADCC_RSRC_SUPPLY   2'h0
`define ADCC_RSRC_EXT      2'h1
`define ADCC_RSRC_FIXED    2'h2

// ****************************************
// conversion clock terminal counts (divide minus one)
// ****************************************
`define ADCC_TC_DIV2       6'h01
`define ADCC_TC_DIV4       6'h03
`define ADCC_TC_DIV8       6'h07
`define ADCC_TC_DIV16      6'h0f
`define ADCC_TC_DIV32      6'h1f
`define ADCC_TC_DIV64      6'h3f
`define ADCC_CLK_RC_LO     2'h3

// ****************************************
// interrupt bits, reset values and conversion start values
// ****************************************
`define ADCC_INT_DONE      0
`define ADCC_INT_REFUSED   1
`define ADCC_INT_W         2
`define ADCC_RST_BYTE      8'h00
`define ADCC_SAR_MSB       8'h80
`define ADCC_BIT_TOP       3'h7

`endif

// [hw/adcc_ctrl.v]
// apb controlled successive-approximation converter control block
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_ctrl (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // analog front end
  input  wire        rc_osc_tick,
  input  wire        cmp_above,
  output reg         power_on,
  output reg  [3:0]  chan_route,
  output reg  [1:0]  ref_route,
  output reg         sample_close,
  output reg  [7:0]  dac_trial,
  // interrupt
  output reg         irq
);

  // ****************************************
  // state and registers
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg        state_r;
  reg        state_nxt;
  reg        on_r;
  reg        go_r;
  reg        go_nxt;
  reg  [3:0] chan_r;
  reg  [7:0] setup_r;
  reg  [7:0] outcome_r;
  reg  [7:0] outcome_nxt;
  reg  [7:0] trial_r;
  reg  [7:0] trial_nxt;
  reg  [2:0] bit_r;
  reg  [2:0] bit_nxt;
  reg  [5:0] div_r;
  reg  [`ADCC_INT_W-1:0] stat_r;
  reg  [`ADCC_INT_W-1:0] stat_nxt;
  reg  [`ADCC_INT_W-1:0] mask_r;
  reg        done_ev;
  reg        refuse_ev;

  wire       wr_acc = psel & penable & pwrite;
  wire       rd_set = psel & ~penable & ~pwrite;
  wire       set_go = psel & ~penable;
  wire [2:0] clk_code = setup_r[`ADCC_SETUP_CLK_HI:`ADCC_SETUP_CLK_LO];
  wire       use_rc = (clk_code[1:0] == `ADCC_CLK_RC_LO);

  // ****************************************
  // helpers
  // ****************************************
  function [5:0] div_tc;
    input [2:0] code;
    begin
      case (code)
        3'h0:    div_tc = `ADCC_TC_DIV2;
        3'h4:    div_tc = `ADCC_TC_DIV4;
        3'h1:    div_tc = `ADCC_TC_DIV8;
        3'h5:    div_tc = `ADCC_TC_DIV16;
        3'h2:    div_tc = `ADCC_TC_DIV32;
        3'h6:    div_tc = `ADCC_TC_DIV64;
        default: div_tc = `ADCC_TC_DIV2;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ADCC_OFF_CTRL) || (a == `ADCC_OFF_SETUP) ||
               (a == `ADCC_OFF_OUTCOME) || (a == `ADCC_OFF_INT_STAT) ||
               (a == `ADCC_OFF_INT_MASK);
    end
  endfunction

  function [1:0] ref_of;
    input [1:0] code;
    begin
      case (code)
        `ADCC_REF_EXT:   ref_of = `ADCC_RSRC_EXT;
        `ADCC_REF_FIXED: ref_of = `ADCC_RSRC_FIXED;
        default:         ref_of = `ADCC_RSRC_SUPPLY;
      endcase
    end
  endfunction

  // ****************************************
  // conversion clock
  // ****************************************
  // divider runs free while powered and not on the rc clock, so the first tick of a conversion
  // comes one to a full divide period after the start
  wire conv_tick = use_rc ? rc_osc_tick : (div_r == div_tc(clk_code));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 6'h00;
    end else if (!on_r || use_rc || conv_tick) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  wire ctrl_wr  = wr_acc && (paddr == `ADCC_OFF_CTRL);
  wire start_rq = ctrl_wr && pwdata[`ADCC_CTRL_GO];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r    <= 1'b0;
      chan_r  <= 4'h0;
      setup_r <= `ADCC_RST_BYTE;
      mask_r  <= {`ADCC_INT_W{1'b0}};
    end else if (wr_acc) begin
      if (paddr == `ADCC_OFF_CTRL) begin
        on_r   <= pwdata[`ADCC_CTRL_ON];
        chan_r <= pwdata[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
      end
      // reserved setup bits are dropped on the way in, so they read zero
      if (paddr == `ADCC_OFF_SETUP) begin
        setup_r <= pwdata[7:0] & `ADCC_SETUP_MASK;
      end
      if (paddr == `ADCC_OFF_INT_MASK) begin
        mask_r <= pwdata[`ADCC_INT_W-1:0];
      end
    end
  end

  // ****************************************
  // successive approximation sequencer
  // ****************************************
  always @* begin
    state_nxt   = state_r;
    go_nxt      = go_r;
    trial_nxt   = trial_r;
    bit_nxt     = bit_r;
    outcome_nxt = outcome_r;
    done_ev     = 1'b0;
    refuse_ev   = 1'b0;
    // a result landing in the same cycle overrides this software write
    if (wr_acc && (paddr == `ADCC_OFF_OUTCOME)) begin
      outcome_nxt = pwdata[7:0];
    end
    case (state_r)
      ST_IDLE: begin
        // a start without the power bit in the same write is refused and flagged
        if (start_rq) begin
          if (pwdata[`ADCC_CTRL_ON]) begin
            state_nxt = ST_CONV;
            go_nxt    = 1'b1;
            trial_nxt = `ADCC_SAR_MSB;
            bit_nxt   = `ADCC_BIT_TOP;
          end else begin
            refuse_ev = 1'b1;
          end
        end
      end
      ST_CONV: begin
        // dropping power aborts; the outcome keeps its old value
        if (!on_r || (ctrl_wr && !pwdata[`ADCC_CTRL_ON])) begin
          state_nxt = ST_IDLE;
          go_nxt    = 1'b0;
        end else if (conv_tick) begin
          trial_nxt = trial_r;
          if (!cmp_above) begin
            trial_nxt[bit_r] = 1'b0;
          end
          if (bit_r == 3'h0) begin
            state_nxt   = ST_IDLE;
            go_nxt      = 1'b0;
            outcome_nxt = trial_nxt;
            done_ev     = 1'b1;
          end else begin
            trial_nxt[bit_r - 3'h1] = 1'b1;
            bit_nxt = bit_r - 3'h1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        go_nxt    = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_IDLE;
      go_r      <= 1'b0;
      trial_r   <= `ADCC_RST_BYTE;
      bit_r     <= `ADCC_BIT_TOP;
      outcome_r <= `ADCC_RST_BYTE;
    end else begin
      state_r   <= state_nxt;
      go_r      <= go_nxt;
      trial_r   <= trial_nxt;
      bit_r     <= bit_nxt;
      outcome_r <= outcome_nxt;
    end
  end

  // ****************************************
  // interrupt status, set wins over clear
  // ****************************************
  always @* begin
    stat_nxt = stat_r;
    // a write-one clear loses to an event in the same cycle
    if (wr_acc && (paddr == `ADCC_OFF_INT_STAT)) begin
      stat_nxt = stat_r & ~pwdata[`ADCC_INT_W-1:0];
    end
    if (done_ev) begin
      stat_nxt[`ADCC_INT_DONE] = 1'b1;
    end
    if (refuse_ev) begin
      stat_nxt[`ADCC_INT_REFUSED] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= {`ADCC_INT_W{1'b0}};
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & mask_r);
    end
  end

  // ****************************************
  // analog side outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on     <= 1'b0;
      chan_route   <= 4'h0;
      ref_route    <= `ADCC_RSRC_SUPPLY;
      sample_close <= 1'b0;
      dac_trial    <= `ADCC_RST_BYTE;
    end else begin
      power_on   <= on_r;
      chan_route <= chan_r;
      ref_route  <= ref_of(setup_r[`ADCC_SETUP_REF_HI:`ADCC_SETUP_REF_LO]);
      // switch is closed only while powered and idle; no discharge path exists
      sample_close <= on_r && (state_nxt == ST_IDLE);
      dac_trial    <= trial_nxt;
    end
  end

  // ****************************************
  // apb read path, zero wait states
  // ****************************************
  // prdata and pslverr are captured in the setup cycle and stand through
  // the access phase, so no wait state is ever needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (set_go) begin
        pslverr <= ~mapped(paddr);
      end
      if (rd_set) begin
        case (paddr)
          `ADCC_OFF_CTRL:     prdata <= {26'h0, chan_r, go_r, on_r};
          `ADCC_OFF_SETUP:    prdata <= {24'h0, setup_r};
          `ADCC_OFF_OUTCOME:  prdata <= {24'h0, outcome_r};
          `ADCC_OFF_INT_STAT: prdata <= {30'h0, stat_r};
          `ADCC_OFF_INT_MASK: prdata <= {30'h0, mask_r};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // adcc_ctrl

// [dv/adcc_ctrl_sva.sv]
// assertions on the ports of the converter control block
`timescale 1ns/1ps
`include "adcc_consts.vh"
module adcc_ctrl_sva (
  // apb side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // analog side
  input wire        power_on,
  input wire [3:0]  chan_route,
  input wire [1:0]  ref_route,
  input wire        sample_close,
  input wire [7:0]  dac_trial,
  input wire        irq
);
  // ******
  // checks
  // ******
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire hit = paddr <= `ADCC_OFF_INT_MASK && paddr[1:0] == 2'h0;
  function automatic [1:0] ref_of(input [1:0] c);
    ref_of = c[1] ? (c[0] ? `ADCC_RSRC_FIXED : `ADCC_RSRC_EXT) : `ADCC_RSRC_SUPPLY;
  endfunction
  a_ready_access: assert property (acc |-> pready)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (acc && !hit && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_mapped_ok: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  a_setup_zero: assert property (acc && !pwrite && paddr == `ADCC_OFF_SETUP
    |-> (prdata & ~32'h73) == 32'h0) else $error("setup spare bits not zero");
  a_outcome_width: assert property (acc && !pwrite && paddr == `ADCC_OFF_OUTCOME
    |-> prdata[31:8] == 24'h0) else $error("outcome wider than a byte");
  a_ctrl_route: assert property (acc && pwrite && paddr == `ADCC_OFF_CTRL
    |=> ##1 power_on == $past(pwdata[0], 2) && chan_route == $past(pwdata[5:2], 2))
    else $error("control write not routed");
  a_ref_map: assert property (acc && pwrite && paddr == `ADCC_OFF_SETUP
    |=> ##1 ref_route == ref_of($past(pwdata[1:0], 2))) else $error("reference routing wrong");
  a_start_trial: assert property ($fell(sample_close) && power_on
    |-> dac_trial == `ADCC_SAR_MSB ##0 !sample_close [*8]) else $error("bad conversion start");
  a_close_power: assert property (sample_close |-> power_on)
    else $error("sampling while powered down");
  c_conv: cover property ($fell(sample_close) && power_on);
  c_irq: cover property ($rose(irq));
  c_refuse: cover property (acc && pslverr);
endmodule // adcc_ctrl_sva
bind adcc_ctrl adcc_ctrl_sva i_adcc_ctrl_sva (.*);

// [dv/adcc_front.sv]
// analog front end model: held input level and rc oscillator
`timescale 1ns/1ps
module adcc_front (
  // clock
  input wire        pclk,
  // analog side
  input wire [7:0]  level,
  input wire        sample_close,
  input wire        power_on,
  input wire [7:0]  dac_trial,
  output logic      cmp_above,
  output logic      rc_osc_tick
);
  // ******
  // model
  // ******
  logic [7:0] held_r = 8'h00;
  logic [2:0] rc_r = 3'h0;
  always @(posedge pclk) begin
    if (sample_close) held_r <= level;
    rc_r <= rc_r + 3'h1;
  end
  assign rc_osc_tick = rc_r == 3'h4;
  // unpowered comparator output is noise
  assign cmp_above = power_on ? held_r >= dac_trial : rc_r[0];
endmodule // adcc_front

// [dv/adcc_ctrl_bench.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_consts.vh"
module adcc_ctrl_bench;
  // ******
  // setup
  // ******
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        rc_osc_tick, cmp_above, power_on, sample_close, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0]  chan_route, ch;
  logic [1:0]  ref_route;
  logic [7:0]  dac_trial, level;
  integer      fails, checks_done, seed, i, n, dv, mdl;
  adcc_ctrl i_adcc_ctrl (.*);
  adcc_front i_adcc_front (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs launched by the access edge are read two edges later
    repeat (2) @(posedge pclk);
    if (k == 50) begin
      fails = fails + 1;
      final_report;
    end
  endtask
  // ******
  // stimulus
  // ******
  initial begin
    seed = 4;
    fails = 0;
    checks_done = 0;
    mdl = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, level} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 5; i = i + 1) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h014, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    for (i = 0; i < 8; i = i + 1) begin
      v = $random(seed);
      v[6:4] = i[2:0];
      v[1:0] = i[1:0];
      apb(1'b1, `ADCC_OFF_SETUP, v);
      chk(ref_route, v[1] ? (v[0] ? 2 : 1) : 0);
      apb(1'b0, `ADCC_OFF_SETUP, 32'h0);
      chk(rd, v & 32'h73);
      ch = (i == 7) ? 4'hf : 4'($random(seed));
      level <= 8'($random(seed));
      apb(1'b1, `ADCC_OFF_CTRL, {26'h0, ch, 2'h1});
      chk(chan_route, ch);
      repeat (4) @(posedge pclk);
      apb(1'b1, `ADCC_OFF_CTRL, {26'h0, ch, 2'h3});
      mdl = level;
      dv = (i[1:0] == 2'h3) ? 8 : 2 << (i[1:0] * 2 + i[2]);
      n = 0;
      rd = 32'h2;
      while (rd[1] && n < 2000) begin
        apb(1'b0, `ADCC_OFF_CTRL, 32'h0);
        n = n + 4;
      end
      chk(n >= 7 * dv && n <= 9 * dv + 12, 1);
      apb(1'b0, `ADCC_OFF_OUTCOME, 32'h0);
      chk(rd, mdl);
      apb(1'b0, `ADCC_OFF_INT_STAT, 32'h0);
      chk({rd[30:0], irq}, 32'h2);
      apb(1'b1, `ADCC_OFF_INT_STAT, 32'h1);
    end
    apb(1'b1, `ADCC_OFF_OUTCOME, 32'h5a);
    apb(1'b0, `ADCC_OFF_OUTCOME, 32'h0);
    chk(rd, 32'h5a);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `ADCC_OFF_INT_MASK, 32'h3);
    apb(1'b1, `ADCC_OFF_CTRL, 32'h2);
    chk(irq, 1);
    apb(1'b1, `ADCC_OFF_INT_MASK, 32'h1);
    chk(irq, 0);
    apb(1'b1, `ADCC_OFF_INT_STAT, 32'h2);
    apb(1'b0, `ADCC_OFF_INT_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `ADCC_OFF_SETUP, 32'h60);
    apb(1'b1, `ADCC_OFF_CTRL, 32'h3);
    repeat (20) @(posedge pclk);
    apb(1'b1, `ADCC_OFF_CTRL, 32'h0);
    apb(1'b0, `ADCC_OFF_CTRL, 32'h0);
    chk({rd[29:0], power_on, irq}, 32'h0);
    apb(1'b0, `ADCC_OFF_OUTCOME, 32'h0);
    chk(rd, 32'h5a);
    if (n >= 2000) fails = fails + 1;
    final_report;
  end
endmodule // adcc_ctrl_bench
